/* ibdc_consts.svh */
`ifndef IBDC_CONSTS_SVH
`define IBDC_CONSTS_SVH
// Register byte addresses
`define IBDC_OFS_CTRL 24'hFFFFA0
`define IBDC_OFS_BA0 24'hFFFFB0
`define IBDC_OFS_BA1 24'hFFFFB4
`define IBDC_OFS_BA2 24'hFFFFB8
`define IBDC_OFS_BA3 24'hFFFFBC
`define IBDC_OFS_BA4 24'hFFFFD0
`define IBDC_OFS_IST 24'hFFFFC0
`define IBDC_OFS_IMSK 24'hFFFFC4
// Control field positions
`define IBDC_POS_BE4 7
`define IBDC_POS_BE3 6
`define IBDC_POS_BE2 5
`define IBDC_POS_REQ 4
`define IBDC_POS_BE1 3
`define IBDC_POS_BE0 2
`define IBDC_POS_STEP 1
`define IBDC_POS_MODE 0
// Interrupt status positions
`define IBDC_POS_IBRK 0
`define IBDC_POS_ISTP 1
`define IBDC_POS_IREQ 2
// Reset values
`define IBDC_RST_CTRL 8'h00
`define IBDC_RST_ADDR 24'h000000
`define IBDC_RST_IRQ 3'h0
`endif

/* ibdc_core_model.sv */
`timescale 1ns/1ps
// ****************
// Core fetch model
// ****************
module ibdc_core_model
   import ibdc_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Core link
   output ibdc_core_in_type core_in,
   input wire ibdc_core_out_type core_out
);
   initial core_in = '0;
   // One fetch, hit sampled in its cycle
   task automatic fetch(input logic [23:0] a, output logic h);
      @(posedge pclk);
      core_in.fetch_valid <= 1'b1;
      core_in.fetch_addr <= a;
      #1 h = core_out.break_hit;
      @(posedge pclk);
      core_in.fetch_valid <= 1'b0;
      core_in.fetch_addr <= ~a;
   endtask : fetch
   task automatic pulse(input logic ex);
      @(posedge pclk);
      core_in.debug_exit <= ex;
      core_in.instr_done <= !ex;
      @(posedge pclk);
      core_in.debug_exit <= 1'b0;
      core_in.instr_done <= 1'b0;
   endtask : pulse
endmodule : ibdc_core_model

/* ibdc_pkg.sv */
package ibdc_pkg;
   // Core fetch and execution signals
   typedef struct packed {
      logic fetch_valid;
      logic [23:0] fetch_addr;
      logic instr_done;
      logic debug_exit;
   } ibdc_core_in_type;
   // Indications to the core
   typedef struct packed {
      logic break_hit;
      logic debug_entry;
      logic debug_mode;
   } ibdc_core_out_type;
   // Debug mode state
   typedef enum logic [0:0] {
      IBDC_USER = 1'b0,
      IBDC_DEBUG = 1'b1
   } ibdc_mode_type;
   // Entry cause code
   typedef enum logic [1:0] {
      IBDC_CAUSE_NONE = 2'b00,
      IBDC_CAUSE_BRK = 2'b01,
      IBDC_CAUSE_STEP = 2'b10,
      IBDC_CAUSE_REQ = 2'b11
   } ibdc_cause_type;
endpackage : ibdc_pkg

/* ibdc_props.sv */
`timescale 1ns/1ps
`include "ibdc_consts.svh"
// ****************
// Port checker
// ****************
module ibdc_props
   import ibdc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [23:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Core side
   input wire ibdc_core_in_type core_in,
   input wire ibdc_core_out_type core_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Read access decode
   wire rd_acc = psel && penable && !pwrite;
   wire ba_hi = paddr == `IBDC_OFS_BA2 || paddr == `IBDC_OFS_BA3 || paddr == `IBDC_OFS_BA4;
   // Mode entry and exit steps
   sequence s_entry;
      core_out.debug_entry && !core_out.debug_mode;
   endsequence
   sequence s_exit;
      core_out.debug_mode && core_in.debug_exit;
   endsequence
   property p_hit_fetch;
      core_out.break_hit |-> core_in.fetch_valid && !core_out.debug_mode;
   endproperty
   a_hit_fetch: assert property (p_hit_fetch) else $error("break without fetch");
   property p_hit_entry;
      core_out.break_hit |-> core_out.debug_entry;
   endproperty
   a_hit_entry: assert property (p_hit_entry) else $error("break without entry");
   property p_entry;
      s_entry |=> core_out.debug_mode;
   endproperty
   a_entry: assert property (p_entry) else $error("entry not taken");
   property p_exit;
      s_exit |=> !core_out.debug_mode;
   endproperty
   a_exit: assert property (p_exit) else $error("exit not taken");
   property p_hold;
      core_out.debug_mode && !core_in.debug_exit |=> core_out.debug_mode;
   endproperty
   a_hold: assert property (p_hold) else $error("debug mode lost");
   property p_user;
      !core_out.debug_mode && !core_out.debug_entry |=> !core_out.debug_mode;
   endproperty
   a_user: assert property (p_user) else $error("mode set without entry");
   property p_mode_read;
      rd_acc && paddr == `IBDC_OFS_CTRL |-> prdata[0] == $past(core_out.debug_mode);
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode bit wrong");
   property p_ctrl_width;
      rd_acc && paddr == `IBDC_OFS_CTRL |-> prdata[31:8] == 24'h000000;
   endproperty
   a_ctrl_width: assert property (p_ctrl_width) else $error("control upper bits");
   property p_ba_top;
      rd_acc && ba_hi |-> prdata[31:24] == 8'h00;
   endproperty
   a_ba_top: assert property (p_ba_top) else $error("reserved bits set");
   property p_err_acc;
      pslverr |-> psel && penable;
   endproperty
   a_err_acc: assert property (p_err_acc) else $error("error outside access");
endmodule : ibdc_props
bind ibdc_top ibdc_props ibdc_props_inst(.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pslverr, .core_in, .core_out);

/* ibdc_top.sv */
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "ibdc_consts.svh"

// Summary of operation
// - An enabled comparator compares every fetch address with its break address.
// - A match on an enabled comparator in user mode raises an instruction break.
// - A disabled comparator never compares and never raises a break.
// - The control byte holds break enables 4,3,2 at D7-D5, request D4, 1,0 at D3-D2, step D1, mode D0.
// - Break address registers hold 24 writable bits and read zero above bit 23.
// - Break addresses reset to zero.
// - The request flag is set when an external debug request occurs.
// - Writing one clears the request flag and writing zero leaves it.
// - The single-step enable is read/write and turns stepping on and off.
// - The read-only mode bit reads one in debug mode and zero in user mode.
// - Enables, request flag and step reset to zero and the mode to user.
module ibdc_top
   import ibdc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [23:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core side
   input wire ibdc_core_in_type core_in,
   output ibdc_core_out_type core_out,
   // External debug request pin
   input wire logic ext_debug_req,
   // Interrupt
   output logic irq
);

   //************************************
   // Declarations
   //************************************

   // Control fields
   logic [4:0] brk_en_reg;
   logic [4:0] brk_en_next;
   logic req_flag_reg;
   logic req_flag_next;
   logic step_en_reg;
   logic step_en_next;
   ibdc_mode_type mode_reg;
   ibdc_mode_type mode_next;
   ibdc_cause_type cause_reg;
   ibdc_cause_type cause_next;

   // Break addresses
   logic [23:0] brk_addr_reg [0:4];
   logic [4:0] brk_hit;

   // Interrupt registers
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_stat_next;
   logic [2:0] irq_mask_reg;
   logic [2:0] irq_mask_next;

   // Request pin synchroniser
   logic req_sync1_reg;
   logic req_sync2_reg;
   logic req_sync3_reg;
   logic req_level_reg;
   logic req_level_next;

   // Bus decode
   logic [23:0] word_addr;
   logic sel_ctrl;
   logic sel_ist;
   logic sel_imsk;
   logic [4:0] sel_ba;
   logic sel_any;
   logic wr_cyc;
   logic rd_setup;
   logic [31:0] byte_mask;
   logic [31:0] wmask_data;
   logic [31:0] rd_mux;
   logic [31:0] prdata_next;
   logic [7:0] ctrl_view;
   logic [31:0] ba_view [0:4];

   // Events
   logic in_user;
   logic req_rise;
   logic brk_event;
   logic step_event;
   logic entry_event;
   logic ctrl_wr;
   logic [7:0] ctrl_wdata;

   //************************************
   // APB decode
   //************************************

   // Word aligned address and selects
   assign word_addr = {paddr[23:2], 2'b00};
   assign sel_ctrl = (word_addr == `IBDC_OFS_CTRL);
   assign sel_ist = (word_addr == `IBDC_OFS_IST);
   assign sel_imsk = (word_addr == `IBDC_OFS_IMSK);
   assign sel_ba[0] = (word_addr == `IBDC_OFS_BA0);
   assign sel_ba[1] = (word_addr == `IBDC_OFS_BA1);
   assign sel_ba[2] = (word_addr == `IBDC_OFS_BA2);
   assign sel_ba[3] = (word_addr == `IBDC_OFS_BA3);
   assign sel_ba[4] = (word_addr == `IBDC_OFS_BA4);
   assign sel_any = sel_ctrl | sel_ist | sel_imsk | (|sel_ba);

   // Write access and read setup strobes
   assign wr_cyc = psel & penable & pwrite & sel_any;
   assign rd_setup = psel & ~penable & ~pwrite;

   // Zero wait state, error on unmapped
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~sel_any;

   // Byte lane mask from strobes
   assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                       {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wmask_data = pwdata & byte_mask;

   //************************************
   // Control byte
   //************************************

   assign ctrl_view[`IBDC_POS_BE4] = brk_en_reg[4];
   assign ctrl_view[`IBDC_POS_BE3] = brk_en_reg[3];
   assign ctrl_view[`IBDC_POS_BE2] = brk_en_reg[2];
   assign ctrl_view[`IBDC_POS_REQ] = req_flag_reg;
   assign ctrl_view[`IBDC_POS_BE1] = brk_en_reg[1];
   assign ctrl_view[`IBDC_POS_BE0] = brk_en_reg[0];
   assign ctrl_view[`IBDC_POS_STEP] = step_en_reg;
   assign ctrl_view[`IBDC_POS_MODE] = (mode_reg == IBDC_DEBUG);

   // Control write on lane 0 only
   assign ctrl_wr = wr_cyc & sel_ctrl & pstrb[0];
   assign ctrl_wdata = pwdata[7:0];

   assign brk_en_next = ctrl_wr ?
      {ctrl_wdata[`IBDC_POS_BE4], ctrl_wdata[`IBDC_POS_BE3],
       ctrl_wdata[`IBDC_POS_BE2], ctrl_wdata[`IBDC_POS_BE1],
       ctrl_wdata[`IBDC_POS_BE0]} : brk_en_reg;
   assign step_en_next = ctrl_wr ? ctrl_wdata[`IBDC_POS_STEP] : step_en_reg;

   // Request flag, set wins over clear
   assign req_flag_next = req_rise ? 1'b1 :
      (ctrl_wr & ctrl_wdata[`IBDC_POS_REQ]) ? 1'b0 : req_flag_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_en_reg <= 5'h00;
         req_flag_reg <= 1'b0;
         step_en_reg <= 1'b0;
      end else begin
         brk_en_reg <= brk_en_next;
         req_flag_reg <= req_flag_next;
         step_en_reg <= step_en_next;
      end
   end

   //************************************
   // Break comparators
   //************************************

   // One comparator and address register per break
   generate
      for (genvar i = 0; i < 5; i++) begin : g_brk
         logic [23:0] addr_next;
         assign addr_next = (wr_cyc & sel_ba[i]) ?
            ((brk_addr_reg[i] & ~byte_mask[23:0]) | wmask_data[23:0]) :
            brk_addr_reg[i];
         assign ba_view[i] = {8'h00, brk_addr_reg[i]};
         assign brk_hit[i] = brk_en_reg[i] & core_in.fetch_valid &
                             (core_in.fetch_addr == brk_addr_reg[i]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               brk_addr_reg[i] <= `IBDC_RST_ADDR;
            end else begin
               brk_addr_reg[i] <= addr_next;
            end
         end
      end
   endgenerate

   //************************************
   // External request pin
   //************************************

   // Three stage synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_sync1_reg <= 1'b0;
         req_sync2_reg <= 1'b0;
         req_sync3_reg <= 1'b0;
         req_level_reg <= 1'b0;
      end else begin
         req_sync1_reg <= ext_debug_req;
         req_sync2_reg <= req_sync1_reg;
         req_sync3_reg <= req_sync2_reg;
         req_level_reg <= req_level_next;
      end
   end

   // Level accepted once stages two and three agree
   assign req_level_next = (req_sync2_reg == req_sync3_reg) ?
                           req_sync3_reg : req_level_reg;
   assign req_rise = req_level_next & ~req_level_reg;

   //************************************
   // Debug mode
   //************************************

   assign in_user = (mode_reg == IBDC_USER);
   assign brk_event = in_user & (|brk_hit);
   assign step_event = in_user & step_en_reg & core_in.instr_done;
   assign entry_event = in_user & (brk_event | step_event | req_rise);

   // Mode transitions
   always_comb begin
      mode_next = mode_reg;
      cause_next = cause_reg;
      unique case (mode_reg)
         IBDC_USER: begin
            if (entry_event) begin
               mode_next = IBDC_DEBUG;
               if (brk_event) begin
                  cause_next = IBDC_CAUSE_BRK;
               end else if (req_rise) begin
                  cause_next = IBDC_CAUSE_REQ;
               end else begin
                  cause_next = IBDC_CAUSE_STEP;
               end
            end
         end
         IBDC_DEBUG: begin
            // Return from debug routine
            if (core_in.debug_exit) begin
               mode_next = IBDC_USER;
               cause_next = IBDC_CAUSE_NONE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= IBDC_USER;
         cause_reg <= IBDC_CAUSE_NONE;
      end else begin
         mode_reg <= mode_next;
         cause_reg <= cause_next;
      end
   end

   // Core indications
   // Break stalls the matching instruction
   assign core_out.break_hit = brk_event;
   assign core_out.debug_entry = entry_event;
   assign core_out.debug_mode = (mode_reg == IBDC_DEBUG);

   //************************************
   // Interrupts
   //************************************

   // Sticky events, set wins over write-one clear
   generate
      for (genvar j = 0; j < 3; j++) begin : g_irq
         logic ev;
         logic clr;
         if (j == `IBDC_POS_IBRK) begin : g_b
            assign ev = brk_event;
         end else if (j == `IBDC_POS_ISTP) begin : g_s
            assign ev = step_event & ~brk_event;
         end else begin : g_r
            assign ev = req_rise;
         end
         assign clr = wr_cyc & sel_ist & pstrb[0] & pwdata[j];
         assign irq_stat_next[j] = ev | (irq_stat_reg[j] & ~clr);
      end
   endgenerate

   // Mask write
   assign irq_mask_next = (wr_cyc & sel_imsk & pstrb[0]) ?
                          pwdata[2:0] : irq_mask_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= `IBDC_RST_IRQ;
         irq_mask_reg <= `IBDC_RST_IRQ;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // Level interrupt
   assign irq = |(irq_stat_reg & irq_mask_reg);

   //************************************
   // Read path
   //************************************

   // Read data select
   assign rd_mux = sel_ctrl ? {24'h000000, ctrl_view} :
                   sel_ba[0] ? ba_view[0] :
                   sel_ba[1] ? ba_view[1] :
                   sel_ba[2] ? ba_view[2] :
                   sel_ba[3] ? ba_view[3] :
                   sel_ba[4] ? ba_view[4] :
                   sel_ist ? {29'h0000000, irq_stat_reg} :
                   sel_imsk ? {29'h0000000, irq_mask_reg} :
                   32'h00000000;

   // Captured in setup, held through access
   assign prdata_next = rd_setup ? rd_mux : prdata;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= prdata_next;
      end
   end

endmodule : ibdc_top

/* testbench.sv */
`timescale 1ns/1ps
`include "ibdc_consts.svh"
// ****************
// Testbench
// ****************
module testbench
   import ibdc_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_debug_req = 0;
   logic [23:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q, d, lfsr = 32'h80D4;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, irq, e, h;
   ibdc_core_in_type core_in;
   ibdc_core_out_type core_out;
   logic [23:0] ofs [5] = '{`IBDC_OFS_BA0, `IBDC_OFS_BA1, `IBDC_OFS_BA2, `IBDC_OFS_BA3,
      `IBDC_OFS_BA4};
   int fail_count = 0, total_checks = 0;
   ibdc_top ibdc_top_inst(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .core_in, .core_out, .ext_debug_req, .irq);
   ibdc_core_model ibdc_core_model_inst(.pclk, .core_in, .core_out);
   // Clock
   always #2 pclk = ~pclk;
   // Random source and expectations
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   function automatic logic [31:0] exp_ba(input logic [31:0] v);
      return {8'h00, v[23:0]};
   endfunction : exp_ba
   function automatic int en_bit(input int i);
      return (i < 2) ? i + 2 : i + 3;
   endfunction : en_bit
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      total_checks++;
      if (got !== want) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : check
   // APB transfer
   task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~v;
   endtask : bus
   task automatic wrap_up();
      $display("checks=%0d failures=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // Watchdog
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      bus(0, `IBDC_OFS_CTRL, 0);
      check(q, 0);
      for (int i = 0; i < 5; i++) begin
         bus(0, ofs[i], 0);
         check(q, 0);
      end
      bus(0, 24'hFFFFE0, 0);
      check(q, 0);
      check({31'h00000000, e}, 1);
      $display("reset test done");
      for (int i = 0; i < 5; i++) begin
         d = (i == 4) ? 32'hFFFFFFFF : rnd();
         bus(1, ofs[i], exp_ba(d));
         bus(0, ofs[i], 0);
         check(q, exp_ba(d));
      end
      pstrb <= 4'h1;
      bus(1, `IBDC_OFS_BA4, 0);
      pstrb <= 4'hF;
      bus(0, `IBDC_OFS_BA4, 0);
      check(q, 32'h00FFFF00);
      $display("address test done");
      bus(1, `IBDC_OFS_IMSK, 1);
      for (int i = 0; i < 5; i++) begin
         d = rnd();
         bus(1, ofs[i], exp_ba(d));
         bus(1, `IBDC_OFS_CTRL, 1 << en_bit(i));
         ibdc_core_model_inst.fetch(d[23:0] ^ 24'h000001, h);
         check(h, 0);
         ibdc_core_model_inst.fetch(d[23:0], h);
         check(h, 1);
         bus(0, `IBDC_OFS_CTRL, 0);
         check(q, (1 << en_bit(i)) | 1);
         check(irq, 1);
         ibdc_core_model_inst.pulse(1);
         bus(1, `IBDC_OFS_IST, 1);
         bus(1, `IBDC_OFS_CTRL, 0);
         #1 check(irq, 0);
         ibdc_core_model_inst.fetch(d[23:0], h);
         check(h, 0);
      end
      $display("break test done");
      bus(1, `IBDC_OFS_IMSK, 0);
      ext_debug_req <= 1'b1;
      repeat (8) @(posedge pclk);
      ext_debug_req <= 1'b0;
      bus(0, `IBDC_OFS_CTRL, 0);
      check(q, 32'h11);
      bus(1, `IBDC_OFS_CTRL, 0);
      bus(0, `IBDC_OFS_CTRL, 0);
      check(q, 32'h11);
      check(irq, 0);
      bus(1, `IBDC_OFS_IMSK, 4);
      #1 check(irq, 1);
      bus(1, `IBDC_OFS_IST, 4);
      #1 check(irq, 0);
      bus(1, `IBDC_OFS_CTRL, 32'h10);
      bus(0, `IBDC_OFS_CTRL, 0);
      check(q, 32'h01);
      ibdc_core_model_inst.pulse(1);
      $display("request test done");
      bus(1, `IBDC_OFS_CTRL, 2);
      bus(0, `IBDC_OFS_CTRL, 0);
      check(q, 2);
      ibdc_core_model_inst.pulse(0);
      bus(0, `IBDC_OFS_CTRL, 0);
      check(q, 3);
      bus(1, `IBDC_OFS_CTRL, 0);
      ibdc_core_model_inst.pulse(1);
      bus(0, `IBDC_OFS_CTRL, 0);
      check(q, 0);
      $display("step test done");
      wrap_up();
   end
endmodule : testbench
